// file: wkc_wake_counter.v
// What this block does
// - each input pin is enabled as an event source by its select bit, others are ignored.
// - with polarity bit 0 a rising edge on a selected pin raises key hit.
// - a detected edge loads the debounce timer, which then counts down each 1 ms tick.
// - the debounce value spans 0 to 63 ms in 1 ms steps.
// - when the timer hits zero and key hit still holds, the event count goes up by one.
// - after a counted edge the machine waits for the opposite edge before idling again.
// - when the count equals the target the count resets and, if enabled, an interrupt rises.
// - any write to the irq clear register clears the match status bit of the wake interrupt, except when a match in the same cycle sets it.
// - any write to the count clear register zeroes the event counter, except when a counted edge in the same cycle increments it.
// - the event count is readable at any time without affecting counting.
// - the interrupt output serves as the wake request from power down.
// - with every pin selected, a change on any pin can lead to the interrupt.
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wkc_map.vh"

module wkc_wake_counter (
    input  wire                  clk_i,   // 40 MHz clock
    input  wire                  rst_i,   // sync reset, high
    input  wire [7:0]            adr_i,   // byte address
    input  wire [31:0]           dat_i,   // write data
    output reg  [31:0]           dat_o,   // read data
    input  wire [3:0]            sel_i,   // byte selects
    input  wire                  we_i,    // write enable
    input  wire                  cyc_i,   // bus cycle
    input  wire                  stb_i,   // strobe
    output reg                   ack_o,   // acknowledge
    input  wire [`WKC_PINS-1:0]  pins_i,  // general purpose inputs
    output wire                  irq_o    // wake interrupt, level
);
    localparam [1:0] ST_IDLE   = 2'd0;
    localparam [1:0] ST_DEB    = 2'd1;
    localparam [1:0] ST_WAIT   = 2'd2;

    reg  [`WKC_PINS-1:0]  pin_event_select;
    reg  [`WKC_PINS-1:0]  pin_edge_polarity;
    reg  [`WKC_DEB_W-1:0] debounce_load_value;
    reg                   irq_enable;
    reg  [`WKC_CNT_W-1:0] event_target_count;
    reg  [`WKC_CNT_W-1:0] event_count;
    reg  [`WKC_ST_W-1:0]  status;
    reg  [`WKC_ST_W-1:0]  mask;
    reg  [`WKC_DEB_W-1:0] deb_timer;
    reg  [`WKC_TICK_W-1:0] tick_cnt;
    reg                   tick;
    reg  [1:0]            state;
    reg  [1:0]            next_state;
    reg  [31:0]           next_dat;
    wire                  key_hit;
    wire                  key_rise;
    wire                  access;
    wire                  wr;
    wire                  count_hit;
    wire                  at_target;
    wire                  irq_clear_strobe;
    wire                  count_clear_strobe;
    wire [`WKC_CNT_W-1:0] count_plus;
    wire                  hit_select;
    wire                  hit_polarity;
    wire                  hit_control;
    wire                  hit_target;
    wire                  hit_irq_clear;
    wire                  hit_cnt_clear;
    wire                  hit_status;
    wire                  hit_mask;
    wire                  status_wr;

    wkc_edge_detect u_edge (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pins_i     (pins_i),
        .select_i   (pin_event_select),
        .polarity_i (pin_edge_polarity),
        .active_o   (key_hit),
        .rise_o     (key_rise)
    );

    // bus decode, ack one cycle after strobe
    assign access = cyc_i & stb_i & ~ack_o;
    assign wr     = access & we_i;

    // one address compare per register, shared by all writers
    assign hit_select    = (adr_i == `WKC_ADR_SELECT);
    assign hit_polarity  = (adr_i == `WKC_ADR_POLARITY);
    assign hit_control   = (adr_i == `WKC_ADR_CONTROL);
    assign hit_target    = (adr_i == `WKC_ADR_TARGET);
    assign hit_irq_clear = (adr_i == `WKC_ADR_IRQ_CLEAR);
    assign hit_cnt_clear = (adr_i == `WKC_ADR_CNT_CLEAR);
    assign hit_status    = (adr_i == `WKC_ADR_STATUS);
    assign hit_mask      = (adr_i == `WKC_ADR_MASK);

    // strobes ignore the written data on purpose
    assign irq_clear_strobe   = wr & hit_irq_clear;
    assign count_clear_strobe = wr & hit_cnt_clear;
    assign status_wr          = wr & hit_status & sel_i[0];

    // 1 ms tick generator
    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= `WKC_RST_TICK;
            tick     <= 1'b0;
        end else if (tick_cnt == `WKC_TICK_LAST) begin
            tick_cnt <= `WKC_RST_TICK;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // event state machine, next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (key_rise) begin
                    next_state = ST_DEB;
                end
            end
            ST_DEB: begin
                if (!key_hit) begin
                    next_state = ST_IDLE;
                end else if (deb_timer == `WKC_RST_DEB) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!key_hit) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign count_hit  = (state == ST_DEB) & key_hit &
                        (deb_timer == `WKC_RST_DEB);
    assign count_plus = event_count + 8'h01;
    assign at_target  = count_hit & (count_plus == event_target_count);

    // state and debounce timer
    always @(posedge clk_i) begin
        if (rst_i) begin
            state     <= ST_IDLE;
            deb_timer <= `WKC_RST_DEB;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && key_rise) begin
                deb_timer <= debounce_load_value;
            end else if (state == ST_DEB && tick &&
                         deb_timer != `WKC_RST_DEB) begin
                deb_timer <= deb_timer - 6'h01;
            end
        end
    end

    // event counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            event_count <= `WKC_RST_CNT;
        end else if (at_target) begin
            event_count <= `WKC_RST_CNT;
        end else if (count_hit) begin
            event_count <= count_plus;
        end else if (count_clear_strobe) begin
            event_count <= `WKC_RST_CNT;
        end
    end

    // sticky status, set wins over clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            status <= {`WKC_ST_W{1'b0}};
        end else begin
            if (at_target && irq_enable) begin
                status[`WKC_ST_MATCH] <= 1'b1;
            end else if (irq_clear_strobe) begin
                status[`WKC_ST_MATCH] <= 1'b0;
            end else if (status_wr && dat_i[`WKC_ST_MATCH]) begin
                status[`WKC_ST_MATCH] <= 1'b0;
            end
            // event bit, a counted edge beats a same-cycle clear
            if (count_hit) begin
                status[`WKC_ST_EVENT] <= 1'b1;
            end else if (status_wr && dat_i[`WKC_ST_EVENT]) begin
                status[`WKC_ST_EVENT] <= 1'b0;
            end
        end
    end

    assign irq_o = |(status & mask);

    // pin_event_select, byte lanes written independently
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_event_select <= {`WKC_PINS{1'b0}};
        end else if (wr && hit_select) begin
            if (sel_i[0]) begin
                pin_event_select[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                pin_event_select[15:8] <= dat_i[15:8];
            end
            if (sel_i[2]) begin
                pin_event_select[23:16] <= dat_i[23:16];
            end
            if (sel_i[3]) begin
                pin_event_select[31:24] <= dat_i[31:24];
            end
        end
    end

    // pin_edge_polarity, byte lanes written independently
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_edge_polarity <= {`WKC_PINS{1'b0}};
        end else if (wr && hit_polarity) begin
            if (sel_i[0]) begin
                pin_edge_polarity[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                pin_edge_polarity[15:8] <= dat_i[15:8];
            end
            if (sel_i[2]) begin
                pin_edge_polarity[23:16] <= dat_i[23:16];
            end
            if (sel_i[3]) begin
                pin_edge_polarity[31:24] <= dat_i[31:24];
            end
        end
    end

    // wake_control, debounce length and interrupt enable
    always @(posedge clk_i) begin
        if (rst_i) begin
            debounce_load_value <= `WKC_RST_DEB;
            irq_enable          <= 1'b0;
        end else if (wr && hit_control && sel_i[0]) begin
            debounce_load_value <=
                dat_i[`WKC_CTL_DEB_MSB:`WKC_CTL_DEB_LSB];
            irq_enable <= dat_i[`WKC_CTL_IRQ_EN];
        end
    end

    // event_target_count, low lane only
    always @(posedge clk_i) begin
        if (rst_i) begin
            event_target_count <= `WKC_RST_TARGET;
        end else if (wr && hit_target && sel_i[0]) begin
            event_target_count <= dat_i[`WKC_CNT_W-1:0];
        end
    end

    // interrupt mask, same layout as status
    always @(posedge clk_i) begin
        if (rst_i) begin
            mask <= {`WKC_ST_W{1'b1}};
        end else if (wr && hit_mask && sel_i[0]) begin
            mask <= dat_i[`WKC_ST_W-1:0];
        end
    end

    // read mux
    always @* begin
        case (adr_i)
            `WKC_ADR_SELECT:   next_dat = pin_event_select;
            `WKC_ADR_POLARITY: next_dat = pin_edge_polarity;
            `WKC_ADR_CONTROL:  next_dat = {24'h0000_00, irq_enable, 1'b0,
                                           debounce_load_value};
            `WKC_ADR_TARGET:   next_dat = {24'h0000_00, event_target_count};
            `WKC_ADR_COUNT:    next_dat = {24'h0000_00, event_count};
            `WKC_ADR_STATUS:   next_dat = {30'h0000_0000, status};
            `WKC_ADR_MASK:     next_dat = {30'h0000_0000, mask};
            default:           next_dat = 32'h0000_0000;
        endcase
    end

    // ack and registered read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            if (access && !we_i) begin
                dat_o <= next_dat;
            end
        end
    end
endmodule // wkc_wake_counter

`default_nettype wire

// file: wkc_map.vh
`ifndef WKC_MAP_VH
`define WKC_MAP_VH

// register byte offsets
`define WKC_ADR_SELECT     8'h00
`define WKC_ADR_POLARITY   8'h04
`define WKC_ADR_CONTROL    8'h08
`define WKC_ADR_TARGET     8'h0C
`define WKC_ADR_IRQ_CLEAR  8'h10
`define WKC_ADR_CNT_CLEAR  8'h14
`define WKC_ADR_COUNT      8'h18
`define WKC_ADR_STATUS     8'h1C
`define WKC_ADR_MASK       8'h20

// widths
`define WKC_PINS           32
`define WKC_DEB_W          6
`define WKC_CNT_W          8
`define WKC_TICK_W         16

// wake_control fields
`define WKC_CTL_DEB_LSB    0
`define WKC_CTL_DEB_MSB    5
`define WKC_CTL_IRQ_EN     7

// status / mask bits
`define WKC_ST_MATCH       0
`define WKC_ST_EVENT       1
`define WKC_ST_W           2

// reset values
`define WKC_RST_DEB        6'h00
`define WKC_RST_CNT        8'h00
`define WKC_RST_TARGET     8'h01
`define WKC_RST_TICK       16'h0000

// timing: 1 ms tick at 40 MHz
`define WKC_CLK_HZ         40000000
`define WKC_TICK_US        1000
`define WKC_TICK_CYCLES    ((`WKC_CLK_HZ / 1000000) * `WKC_TICK_US)
// last tick count value, 40000 cycles minus one, at counter width
`define WKC_TICK_LAST      16'h9C3F

`endif

// file: wkc_edge_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "wkc_map.vh"

module wkc_edge_detect (
    input  wire                  clk_i,      // system clock
    input  wire                  rst_i,      // sync reset, high
    input  wire [`WKC_PINS-1:0]  pins_i,     // input pins
    input  wire [`WKC_PINS-1:0]  select_i,   // pin_event_select
    input  wire [`WKC_PINS-1:0]  polarity_i, // pin_edge_polarity
    output wire                  active_o,   // any selected pin in active level
    output wire                  rise_o      // active level began
);
    wire [`WKC_PINS-1:0] act;
    reg                  prev_act;
    genvar               g;

    // per pin active level, polarity flips the sense
    generate
        for (g = 0; g < `WKC_PINS; g = g + 1) begin : g_pin
            assign act[g] = select_i[g] & (pins_i[g] ^ polarity_i[g]);
        end
    endgenerate

    assign active_o = |act;
    assign rise_o   = active_o & ~prev_act;

    // previous sample for edge detection
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_act  <= 1'b1;
        end else begin
            prev_act  <= active_o;
        end
    end
endmodule // wkc_edge_detect

`default_nettype wire

// file: wkc_wake_counter_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "wkc_map.vh"
module wkc_wake_counter_properties (
    input wire logic        clk_i,  // clock
    input wire logic        rst_i,  // sync reset
    input wire logic [7:0]  adr_i,  // address
    input wire logic [31:0] dat_i,  // write data
    input wire logic [31:0] dat_o,  // read data
    input wire logic [3:0]  sel_i,  // lanes
    input wire logic        we_i,   // write
    input wire logic        cyc_i,  // cycle
    input wire logic        stb_i,  // strobe
    input wire logic        ack_o,  // ack
    input wire logic [31:0] pins_i, // pins
    input wire logic        irq_o   // interrupt
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus answer shape
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    // readback leaves data alone outside reads
    chk_data_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
        else $error("read data moved without read");
    chk_unmapped_zero: assert property
        (ack_o && !we_i && adr_i > 8'h20 |-> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_count_width: assert property (ack_o && !we_i &&
        adr_i == `WKC_ADR_COUNT |-> dat_o[31:8] == 24'h00_0000)
        else $error("count wider than 8 bits");
    chk_status_width: assert property (ack_o && !we_i &&
        adr_i == `WKC_ADR_STATUS |-> dat_o[31:2] == 30'h0000_0000)
        else $error("status spare bits set");
    // interrupt level only drops after a write
    chk_irq_sticky: assert property ($fell(irq_o) |->
        ack_o && we_i)
        else $error("irq dropped by itself");
endmodule // wkc_wake_counter_properties
bind wkc_wake_counter wkc_wake_counter_properties wkc_props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .pins_i(pins_i), .irq_o(irq_o));
`default_nettype wire

// file: wkc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module wkc_pin_model (
    input  wire logic        clk_i,  // clock
    output var  logic [31:0] pins_o  // switch levels
);
    // switches rest low
    initial begin
        pins_o = 32'h0000_0000;
    end
    // new levels land just after an edge
    task automatic set_pins(input logic [31:0] v);
        @(posedge clk_i);
        pins_o <= v;
    endtask
endmodule // wkc_pin_model
`default_nettype wire

// file: wkc_wake_counter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wkc_map.vh"
module wkc_wake_counter_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0000_0000;
    logic        we    = 1'b0;
    logic        cyc   = 1'b0;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire         irq_o;
    wire  [31:0] pins;
    logic [31:0] exp_q [$];
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles    = 0;
    logic [31:0] pb;
    logic [31:0] pc;
    int          k;
    // clock, 25 ns
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    wkc_wake_counter wkc_wake_counter_inst (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .sel_i(4'hf), .we_i(we),
        .cyc_i(cyc), .stb_i(cyc), .ack_o(ack_o), .pins_i(pins),
        .irq_o(irq_o));
    wkc_pin_model wkc_pin_model_inst (.clk_i(clk_i), .pins_o(pins));
    task check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task tally_and_finish;
        if (err_total == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // read answers against the oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            check(dat_o, exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            tally_and_finish;
        end
    end
    // classic cycle, held until ack sampled
    task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge clk_i);
        cyc <= 1'b1;
        adr <= a;
        dat <= d;
        we  <= w;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc <= 1'b0;
        we  <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 32'h0000_0000, 1'b0);
    endtask
    task pins_to(input logic [31:0] v);
        wkc_pin_model_inst.set_pins(v);
        repeat (6) @(posedge clk_i);
    endtask
    task irq_is(input logic e);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, {31'h0, e});
    endtask
    // main sequence
    initial begin
        void'($urandom(32'ha8485ac2));
        pb = 32'h0000_0001 << ($urandom % 32);
        k  = 1 + ($urandom % 31);
        pc = (pb << k) | (pb >> (32 - k));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`WKC_ADR_SELECT, 32'h0000_0000);
        rd(`WKC_ADR_POLARITY, 32'h0000_0000);
        rd(`WKC_ADR_CONTROL, 32'h0000_0000);
        rd(`WKC_ADR_TARGET, 32'h0000_0001);
        rd(`WKC_ADR_COUNT, 32'h0000_0000);
        rd(`WKC_ADR_STATUS, 32'h0000_0000);
        rd(`WKC_ADR_MASK, 32'h0000_0003);
        rd(8'h24, 32'h0000_0000);
        wb(`WKC_ADR_SELECT, pb, 1'b1);
        wb(`WKC_ADR_MASK, 32'h0000_0001, 1'b1);
        wb(`WKC_ADR_CONTROL, 32'h0000_0080, 1'b1);
        wb(`WKC_ADR_TARGET, 32'h0000_0003, 1'b1);
        pins_to(pc);
        pins_to(32'h0000_0000);
        rd(`WKC_ADR_COUNT, 32'h0000_0000);
        pins_to(pb);
        pins_to(32'h0000_0000);
        rd(`WKC_ADR_COUNT, 32'h0000_0001);
        pins_to(pb);
        pins_to(32'h0000_0000);
        irq_is(1'b0);
        pins_to(pb);
        pins_to(32'h0000_0000);
        rd(`WKC_ADR_COUNT, 32'h0000_0000);
        irq_is(1'b1);
        wb(`WKC_ADR_MASK, 32'h0000_0000, 1'b1);
        irq_is(1'b0);
        wb(`WKC_ADR_MASK, 32'h0000_0001, 1'b1);
        irq_is(1'b1);
        wb(`WKC_ADR_IRQ_CLEAR, $urandom, 1'b1);
        irq_is(1'b0);
        // rise counts, then a fall counts once polarity flips
        pins_to(pb);
        wb(`WKC_ADR_POLARITY, pb, 1'b1);
        pins_to(32'h0000_0000);
        rd(`WKC_ADR_COUNT, 32'h0000_0002);
        wb(`WKC_ADR_CNT_CLEAR, $urandom, 1'b1);
        rd(`WKC_ADR_COUNT, 32'h0000_0000);
        // every pin selected, second pin while held is no new edge
        wb(`WKC_ADR_POLARITY, 32'h0000_0000, 1'b1);
        wb(`WKC_ADR_SELECT, 32'hffff_ffff, 1'b1);
        wb(`WKC_ADR_TARGET, 32'h0000_0002, 1'b1);
        wb(`WKC_ADR_STATUS, 32'h0000_0003, 1'b1);
        pins_to(pc);
        pins_to(pc | pb);
        rd(`WKC_ADR_COUNT, 32'h0000_0001);
        pins_to(32'h0000_0000);
        pins_to(pb);
        pins_to(32'h0000_0000);
        irq_is(1'b1);
        // one millisecond debounce
        wb(`WKC_ADR_CONTROL, 32'h0000_00bf, 1'b1);
        rd(`WKC_ADR_CONTROL, 32'h0000_00bf);
        wb(`WKC_ADR_CONTROL, 32'h0000_0081, 1'b1);
        pins_to(pb);
        rd(`WKC_ADR_COUNT, 32'h0000_0000);
        repeat (40010) @(posedge clk_i);
        rd(`WKC_ADR_COUNT, 32'h0000_0001);
        pins_to(32'h0000_0000);
        tally_and_finish;
    end
endmodule // wkc_wake_counter_tb_top
`default_nettype wire
